// ### hw/mfptr_regs.sv
// Fault latch, pin three control, time-base divider and timer scaling slice
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RQ1] Latch input fault for each pin held at active level as input.
// [RQ2] Latch wake-up fault on stuck-bus wake only when option bit set.
// [RQ3] Latch energy overflow fault; zero until an energy overflow.
// [RQ4] Latch charge overflow fault; zero until a charge overflow.
// [RQ5] Latch time counter overflow fault; reset zero until overflow.
// [RQ6] Pin three in alert mode pulls low while alert flag set.
// [RQ7] Alert flag does not touch pin three in other modes.
// [RQ8] Alert flag sets on alert event or host writing one.
// [RQ9] Host clears alert flag by writing zero over the bus.
// [RQ10] Pull-down bit drives pin three low in output mode, else Hi-Z.
// [RQ11] Divide time-base input by four times divider; reset four, top bits zero.
// [RQ12] Twelve-bit results: bits 11..4 high byte, 3..0 upper low nibble.
// [RQ13] Power results: 24 bits over three bytes, most significant first.
// [RQ14] Counter and accumulators: 32 bits over four bytes, MSB first.
// [RQ15] Timer LSB factor looked up from conversion mode fields.
// [RQ16] Timer LSB time is factor times four times divider, or four us.
// [RQ17] Fault bits stay set until written zero; writing one clears nothing.
// [RQ18] Multi-byte reads come from one held sample.
module mfptr_regs (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire mfptr_pkg::mfptr_pin_cfg_type pin_cfg_in,
  input wire logic multi_pin_one_in,
  input wire logic multi_pin_two_in,
  input wire logic multi_pin_three_in,
  output logic multi_pin_three_out,
  output logic multi_pin_three_oe_n_out,
  input wire mfptr_pkg::mfptr_events_type events_in,
  input wire logic [7:0] control_b_bits_in,
  input wire logic [7:0] conversion_mode_bits_in,
  input wire logic ext_clock_sel_in,
  input wire logic timebase_input_in,
  output logic sys_tick_out,
  output logic [7:0] fault_latch_bits_out,
  output logic [7:0] pin3_control_bits_out,
  output logic [4:0] divider_bits_out,
  output logic [25:0] lsb_factor_out,
  output logic [32:0] lsb_time_out,
  input wire logic [1:0] res_kind_in,
  input wire logic [31:0] res_value_in,
  input wire logic [1:0] res_byte_sel_in,
  input wire logic res_rd_in,
  output logic [7:0] res_byte_out
);

  // Input active decode, shared by all three pins
  function automatic logic pin_active(input mfptr_pkg::mfptr_pin_mode_type mode, input logic level);
    logic act;
    act = 1'b0;
    unique case (mode)
      mfptr_pkg::PIN_IN_HIGH: act = level;
      mfptr_pkg::PIN_IN_LOW: act = ~level;
      mfptr_pkg::PIN_OUT: act = 1'b0;
      mfptr_pkg::PIN_ALT: act = 1'b0;
    endcase
    return act;
  endfunction

  // Timer LSB factor lookup in 1e-4 units
  function automatic logic [25:0] lsb_factor(input logic [1:0] mode, input logic [2:0] sel);
    logic [1:0] row;
    logic [15:0] delta;
    logic valid;
    row = ~mode;
    delta = 16'h0000;
    valid = 1'b1;
    unique case (sel)
      3'b110: delta = mfptr_pkg::FACTOR_DELTA_SEL110;
      3'b011: delta = mfptr_pkg::FACTOR_DELTA[row][0];
      3'b010, 3'b101: delta = mfptr_pkg::FACTOR_DELTA[row][1];
      3'b001, 3'b100: delta = mfptr_pkg::FACTOR_DELTA[row][2];
      3'b000: delta = mfptr_pkg::FACTOR_DELTA[row][3];
      default: valid = 1'b0;
    endcase
    return valid ? (mfptr_pkg::FACTOR_BASE + {10'h000, delta}) : 26'h000_0000;
  endfunction

  // Write strobe decode for one register address
  function automatic logic reg_write_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  logic [6:0] fault_bits;
  logic [7:0] pin3_bits;
  logic [4:0] divider;
  logic [2:0] pin_level;
  logic [2:0] pin_hit;
  mfptr_pkg::mfptr_pin_mode_type pin_mode [3];
  logic [6:0] fault_set;
  logic [6:0] next_fault;
  logic wr_fault;
  logic wr_pin3;
  logic wr_divider;
  logic alert_set;
  logic next_alert;
  logic [7:0] read_value;
  logic tb_prev;
  logic tb_rise;
  logic [6:0] tb_count;
  logic [6:0] tb_terminal;
  logic [6:0] time_mult;
  logic [25:0] factor;
  logic [32:0] next_lsb_time;

  assign wr_fault = reg_write_hit(reg_wr_in, reg_addr_in, mfptr_pkg::ADDR_FAULT_LATCH);
  assign wr_pin3 = reg_write_hit(reg_wr_in, reg_addr_in, mfptr_pkg::ADDR_PIN3_CTRL);
  assign wr_divider = reg_write_hit(reg_wr_in, reg_addr_in, mfptr_pkg::ADDR_DIVIDER);

  assign pin_level = {multi_pin_one_in, multi_pin_two_in, multi_pin_three_in};
  assign pin_mode[0] = pin_cfg_in.pin_three;
  assign pin_mode[1] = pin_cfg_in.pin_two;
  assign pin_mode[2] = pin_cfg_in.pin_one;

  // Per-pin input fault detection
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      assign pin_hit[gi] = pin_active(pin_mode[gi], pin_level[gi]); // [RQ1]
    end
  endgenerate

  // Fault set terms
  always_comb begin
    fault_set = 7'h00;
    fault_set[mfptr_pkg::FAULT_PIN1_BIT] = pin_hit[2]; // [RQ1]
    fault_set[mfptr_pkg::FAULT_PIN2_BIT] = pin_hit[1]; // [RQ1]
    fault_set[mfptr_pkg::FAULT_PIN3_BIT] = pin_hit[0]; // [RQ1]
    fault_set[mfptr_pkg::FAULT_WAKE_BIT] = events_in.stuck_wake &
      control_b_bits_in[mfptr_pkg::CTRLB_WAKE_EN_BIT]; // [RQ2]
    fault_set[mfptr_pkg::FAULT_ENERGY_BIT] = events_in.energy_ovf; // [RQ3]
    fault_set[mfptr_pkg::FAULT_CHARGE_BIT] = events_in.charge_ovf; // [RQ4]
    fault_set[mfptr_pkg::FAULT_TIME_BIT] = events_in.time_ovf; // [RQ5]
  end

  // Write zero clears, write one keeps, a set in the same cycle wins
  always_comb begin
    next_fault = fault_bits;
    if (wr_fault) begin
      next_fault = fault_bits & reg_wdata_in[6:0]; // [RQ17]
    end
    next_fault = next_fault | fault_set; // [RQ17]
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_bits <= mfptr_pkg::FAULT_RESET[6:0]; // [RQ5]
    end else begin
      fault_bits <= next_fault; // [RQ3] [RQ4] [RQ5]
    end
  end

  // Alert flag: event or written one sets, written zero clears, set wins
  assign alert_set = events_in.alert | (wr_pin3 & reg_wdata_in[mfptr_pkg::PIN3_ALERT_BIT]); // [RQ8]

  always_comb begin
    next_alert = pin3_bits[mfptr_pkg::PIN3_ALERT_BIT];
    if (wr_pin3) begin
      next_alert = reg_wdata_in[mfptr_pkg::PIN3_ALERT_BIT]; // [RQ9]
    end
    if (alert_set) begin
      next_alert = 1'b1; // [RQ8]
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin3_bits <= mfptr_pkg::PIN3_RESET;
    end else begin
      pin3_bits[mfptr_pkg::PIN3_ALERT_BIT] <= next_alert;
      if (wr_pin3) begin
        pin3_bits[mfptr_pkg::PIN3_PULL_BIT] <= reg_wdata_in[mfptr_pkg::PIN3_PULL_BIT]; // [RQ10]
      end
      pin3_bits[5:0] <= 6'h00;
    end
  end

  // Divider integer, upper bits not stored
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      divider <= mfptr_pkg::DIVIDER_RESET; // [RQ11]
    end else if (wr_divider) begin
      divider <= reg_wdata_in[4:0]; // [RQ11]
    end
  end

  // Pin three open-drain drive, output enable low while driving
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      multi_pin_three_out <= 1'b0;
      multi_pin_three_oe_n_out <= 1'b1;
    end else begin
      multi_pin_three_out <= 1'b0;
      unique case (pin_cfg_in.pin_three)
        mfptr_pkg::PIN_ALT: multi_pin_three_oe_n_out <= ~pin3_bits[mfptr_pkg::PIN3_ALERT_BIT]; // [RQ6]
        mfptr_pkg::PIN_OUT: multi_pin_three_oe_n_out <= ~pin3_bits[mfptr_pkg::PIN3_PULL_BIT]; // [RQ7] [RQ10]
        mfptr_pkg::PIN_IN_HIGH: multi_pin_three_oe_n_out <= 1'b1; // [RQ7] [RQ10]
        mfptr_pkg::PIN_IN_LOW: multi_pin_three_oe_n_out <= 1'b1; // [RQ7] [RQ10]
      endcase
    end
  end

  // Time-base divider: one tick per four times divider input rising edges
  assign tb_rise = timebase_input_in & ~tb_prev;

  // Terminal count is four times divider less one; zero divides by four
  always_comb begin
    if (divider == 5'h00) begin
      tb_terminal = 7'h03; // [RQ11]
    end else begin
      tb_terminal = {divider, 2'b00} - 7'h01; // [RQ11]
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tb_prev <= 1'b0;
      tb_count <= 7'h00;
      sys_tick_out <= 1'b0;
    end else begin
      tb_prev <= timebase_input_in;
      sys_tick_out <= 1'b0;
      if (tb_rise) begin
        if (tb_count >= tb_terminal) begin
          tb_count <= 7'h00; // [RQ11]
          sys_tick_out <= 1'b1; // [RQ11]
        end else begin
          tb_count <= tb_count + 7'h01;
        end
      end
    end
  end

  // Timer LSB weighting and period
  assign factor = lsb_factor(conversion_mode_bits_in[6:5], conversion_mode_bits_in[2:0]); // [RQ15]
  assign time_mult = ext_clock_sel_in ? {divider, 2'b00} : mfptr_pkg::INT_CLK_MULT; // [RQ16]
  assign next_lsb_time = 33'(factor) * 33'(time_mult); // [RQ16]

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lsb_factor_out <= 26'h000_0000;
      lsb_time_out <= 33'h0_0000_0000;
    end else begin
      lsb_factor_out <= factor; // [RQ15]
      lsb_time_out <= next_lsb_time; // [RQ16]
    end
  end

  // Register read mux
  always_comb begin
    read_value = 8'h00;
    unique case (reg_addr_in)
      mfptr_pkg::ADDR_FAULT_LATCH: read_value = {mfptr_pkg::FAULT_RSVD_VALUE, fault_bits};
      mfptr_pkg::ADDR_PIN3_CTRL: read_value = {pin3_bits[7:6], 6'h00};
      mfptr_pkg::ADDR_DIVIDER: read_value = {3'h0, divider}; // [RQ11]
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= read_value;
    end
  end

  // Mirrors of the register contents
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_latch_bits_out <= {mfptr_pkg::FAULT_RSVD_VALUE, mfptr_pkg::FAULT_RESET[6:0]};
      pin3_control_bits_out <= mfptr_pkg::PIN3_RESET;
      divider_bits_out <= mfptr_pkg::DIVIDER_RESET;
    end else begin
      fault_latch_bits_out <= {mfptr_pkg::FAULT_RSVD_VALUE, fault_bits};
      pin3_control_bits_out <= {pin3_bits[7:6], 6'h00};
      divider_bits_out <= divider;
    end
  end

  // Multi-byte result byte view
  mfptr_result_bytes u_result_bytes (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .res_kind_in(res_kind_in),
    .res_value_in(res_value_in),
    .res_byte_sel_in(res_byte_sel_in),
    .res_rd_in(res_rd_in),
    .res_byte_out(res_byte_out)
  );

endmodule

`default_nettype wire

// ### hw/mfptr_result_bytes.sv
// Byte view of multi-byte results with a snapshot taken at the first byte
`timescale 1ns/1ps
`default_nettype none

module mfptr_result_bytes (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] res_kind_in,
  input wire logic [31:0] res_value_in,
  input wire logic [1:0] res_byte_sel_in,
  input wire logic res_rd_in,
  output logic [7:0] res_byte_out
);

  logic [31:0] snapshot;
  logic [31:0] source;
  logic [7:0] next_byte;

  // First byte reads live value, later bytes read the held sample
  always_comb begin
    source = (res_byte_sel_in == 2'h0) ? res_value_in : snapshot; // [RQ18]
  end

  always_comb begin
    next_byte = 8'h00;
    unique case (res_kind_in)
      mfptr_pkg::RES_KIND_12: begin
        if (res_byte_sel_in == 2'h0) next_byte = source[11:4]; // [RQ12]
        else if (res_byte_sel_in == 2'h1) next_byte = {source[3:0], 4'h0}; // [RQ12]
      end
      mfptr_pkg::RES_KIND_24: begin
        if (res_byte_sel_in == 2'h0) next_byte = source[23:16]; // [RQ13]
        else if (res_byte_sel_in == 2'h1) next_byte = source[15:8]; // [RQ13]
        else if (res_byte_sel_in == 2'h2) next_byte = source[7:0]; // [RQ13]
      end
      mfptr_pkg::RES_KIND_32: begin
        unique case (res_byte_sel_in)
          2'h0: next_byte = source[31:24]; // [RQ14]
          2'h1: next_byte = source[23:16]; // [RQ14]
          2'h2: next_byte = source[15:8]; // [RQ14]
          2'h3: next_byte = source[7:0]; // [RQ14]
        endcase
      end
      default: next_byte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      snapshot <= 32'h0000_0000;
    end else if (res_rd_in && res_byte_sel_in == 2'h0) begin
      snapshot <= res_value_in; // [RQ18]
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      res_byte_out <= 8'h00;
    end else if (res_rd_in) begin
      res_byte_out <= next_byte;
    end
  end

endmodule

`default_nettype wire

// ### include/mfptr_pkg.sv
// Package for the fault latch, pin three control and time-base register slice
package mfptr_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_FAULT_LATCH = 8'h41;
  localparam logic [7:0] ADDR_PIN3_CTRL = 8'h42;
  localparam logic [7:0] ADDR_DIVIDER = 8'h43;

  // Fault latch field positions
  localparam int FAULT_RSVD_BIT = 7;
  localparam int FAULT_PIN1_BIT = 6;
  localparam int FAULT_PIN2_BIT = 5;
  localparam int FAULT_PIN3_BIT = 4;
  localparam int FAULT_WAKE_BIT = 3;
  localparam int FAULT_ENERGY_BIT = 2;
  localparam int FAULT_CHARGE_BIT = 1;
  localparam int FAULT_TIME_BIT = 0;

  // Pin three control field positions
  localparam int PIN3_ALERT_BIT = 7;
  localparam int PIN3_PULL_BIT = 6;

  // Stuck-bus wake-up enable in control register B
  localparam int CTRLB_WAKE_EN_BIT = 4;

  // Reset values
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic FAULT_RSVD_VALUE = 1'b1;
  localparam logic [7:0] PIN3_RESET = 8'h00;
  localparam logic [4:0] DIVIDER_RESET = 5'h04;

  // Multi-byte result layouts
  localparam logic [1:0] RES_KIND_12 = 2'h0;
  localparam logic [1:0] RES_KIND_24 = 2'h1;
  localparam logic [1:0] RES_KIND_32 = 2'h2;

  // Internal clock multiplier per timer LSB (4 us units of the 250 kHz clock)
  localparam logic [6:0] INT_CLK_MULT = 7'h04;

  // Timer LSB weighting factor in units of 1e-4, as base plus delta
  localparam logic [25:0] FACTOR_BASE = 26'h271_4E20;
  localparam logic [15:0] FACTOR_DELTA_SEL110 = 16'h1388;
  // Rows: mode field 11,10,01,00; columns: selector 011, 010/101, 001/100, 000
  localparam logic [0:3][0:3][15:0] FACTOR_DELTA = '{
    '{16'h445C, 16'h13EA, 16'h16AE, 16'h3415},
    '{16'h43CB, 16'h13E9, 16'h16A8, 16'h34ED},
    '{16'h402D, 16'h13E4, 16'h167E, 16'h3194},
    '{16'h2710, 16'h13B9, 16'h1515, 16'h217B}
  };

  // Multipurpose pin configuration codes
  typedef enum logic [1:0] {
    PIN_IN_HIGH = 2'b11,
    PIN_IN_LOW = 2'b10,
    PIN_OUT = 2'b01,
    PIN_ALT = 2'b00
  } mfptr_pin_mode_type;

  typedef struct packed {
    mfptr_pin_mode_type pin_one;
    mfptr_pin_mode_type pin_two;
    mfptr_pin_mode_type pin_three;
  } mfptr_pin_cfg_type;

  typedef struct packed {
    logic alert;
    logic stuck_wake;
    logic energy_ovf;
    logic charge_ovf;
    logic time_ovf;
  } mfptr_events_type;

endpackage

// ### test/mfptr_host.sv
// Host model driving the register byte port
`timescale 1ns/1ps
`default_nettype none
module mfptr_host (
  input wire logic mclk_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // Byte write, strobe held across one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask
  // Byte read, data taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'b0;
    d = reg_rdata_in;
  endtask
endmodule
`default_nettype wire

// ### test/mfptr_regs_assertions.sv
// Checker watching the register slice ports
`timescale 1ns/1ps
`default_nettype none
module mfptr_regs_chk (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire mfptr_pkg::mfptr_pin_cfg_type pin_cfg_in,
  input wire logic multi_pin_three_oe_n_out,
  input wire mfptr_pkg::mfptr_events_type events_in,
  input wire logic [7:0] control_b_bits_in,
  input wire logic [7:0] conversion_mode_bits_in,
  input wire logic [7:0] fault_latch_bits_out,
  input wire logic [7:0] pin3_control_bits_out,
  input wire logic [25:0] lsb_factor_out
);
  logic fault_wr;
  logic [1:0] p3;
  assign fault_wr = reg_wr_in && reg_addr_in == mfptr_pkg::ADDR_FAULT_LATCH;
  assign p3 = pin_cfg_in.pin_three;
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_sets(logic ev, logic b);
    ev |-> ##[1:2] b;
  endproperty
  a_energy_fault_set: assert property (p_sets(events_in.energy_ovf, fault_latch_bits_out[2]))
    else $error("energy overflow not latched");
  a_charge_fault_set: assert property (p_sets(events_in.charge_ovf, fault_latch_bits_out[1]))
    else $error("charge overflow not latched");
  a_time_fault_set: assert property (p_sets(events_in.time_ovf, fault_latch_bits_out[0]))
    else $error("time overflow not latched");
  a_wake_fault_set: assert property (p_sets(events_in.stuck_wake && control_b_bits_in[4],
    fault_latch_bits_out[3])) else $error("wake-up fault not latched");
  a_fault_bits_hold: assert property (|($past(fault_latch_bits_out) & ~fault_latch_bits_out) |->
    $past(fault_wr, 2)) else $error("fault bit dropped without a write");
  a_alert_flag_set: assert property (p_sets(events_in.alert, pin3_control_bits_out[7]))
    else $error("alert flag not set by alert");
  a_alert_pin_low: assert property (p3 == mfptr_pkg::PIN_ALT ##1 p3 == mfptr_pkg::PIN_ALT |->
    multi_pin_three_oe_n_out == !pin3_control_bits_out[7]) else $error("alert pin level wrong");
  a_input_pin_free: assert property (p3[1] ##1 p3[1] |-> multi_pin_three_oe_n_out)
    else $error("input pin driven");
  a_output_pull_low: assert property (p3 == mfptr_pkg::PIN_OUT ##1 p3 == mfptr_pkg::PIN_OUT |->
    multi_pin_three_oe_n_out == !pin3_control_bits_out[6]) else $error("output pull-down wrong");
  a_factor_sel_six: assert property (conversion_mode_bits_in[2:0] == 3'b110 |=>
    lsb_factor_out == 26'h271_61A8) else $error("timer factor wrong for selector 110");
  a_divider_top_zero: assert property (reg_rd_in && reg_addr_in == mfptr_pkg::ADDR_DIVIDER |=>
    reg_rdata_out[7:5] == 3'b000) else $error("divider upper bits not zero");
  c_fault_write: cover property (fault_wr);
  c_alert_event: cover property (events_in.alert);
  c_pull_low: cover property (p3 == mfptr_pkg::PIN_OUT && !multi_pin_three_oe_n_out);
endmodule
bind mfptr_regs mfptr_regs_chk u_mfptr_regs_chk (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pin_cfg_in(pin_cfg_in),
  .multi_pin_three_oe_n_out(multi_pin_three_oe_n_out), .events_in(events_in),
  .control_b_bits_in(control_b_bits_in), .conversion_mode_bits_in(conversion_mode_bits_in),
  .fault_latch_bits_out(fault_latch_bits_out), .pin3_control_bits_out(pin3_control_bits_out),
  .lsb_factor_out(lsb_factor_out)
);
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the register slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] FA = mfptr_pkg::ADDR_FAULT_LATCH;
  localparam logic [7:0] PA = mfptr_pkg::ADDR_PIN3_CTRL;
  localparam logic [7:0] DA = mfptr_pkg::ADDR_DIVIDER;
  logic mclk_in = 1'b0, reset_n_in = 1'b0, wr, rd, p1 = 1'b0, p2 = 1'b1, p3 = 1'b0;
  logic ext = 1'b0, tb_in = 1'b0, tick, res_rd = 1'b0, oe_n, p3_out;
  logic [4:0] divm;
  logic [7:0] addr, wdata, rdata, d, res_byte, cb_bits = 8'h00, mode = 8'h00;
  mfptr_pkg::mfptr_pin_cfg_type cfg = '0;
  mfptr_pkg::mfptr_events_type ev = '0;
  logic [1:0] kind = 2'h0, sel = 2'h0;
  logic [31:0] val = 32'h0000_0000;
  logic [25:0] factor;
  logic [32:0] ltime;
  int bad_count = 0, compares = 0, ticks = 0;
  mfptr_host u_mfptr_host (.mclk_in(mclk_in), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_wdata_out(wdata), .reg_rdata_in(rdata));
  mfptr_regs u_mfptr_regs (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .pin_cfg_in(cfg), .multi_pin_one_in(p1),
    .multi_pin_two_in(p2), .multi_pin_three_in(p3), .multi_pin_three_out(p3_out), .multi_pin_three_oe_n_out(oe_n),
    .events_in(ev), .control_b_bits_in(cb_bits), .conversion_mode_bits_in(mode), .ext_clock_sel_in(ext),
    .timebase_input_in(tb_in), .sys_tick_out(tick), .fault_latch_bits_out(), .pin3_control_bits_out(),
    .divider_bits_out(divm), .lsb_factor_out(factor), .lsb_time_out(ltime), .res_kind_in(kind),
    .res_value_in(val), .res_byte_sel_in(sel), .res_rd_in(res_rd), .res_byte_out(res_byte)
  );
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (tick === 1'b1) begin
      ticks++;
    end
  end
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_mfptr_host.rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask
  task automatic pulse(input mfptr_pkg::mfptr_events_type e);
    step(1);
    ev = e;
    step(1);
    ev = '0;
  endtask
  task automatic rbyte(input logic [1:0] s, input logic [7:0] e);
    step(1);
    sel = s;
    res_rd = 1'b1;
    step(1);
    res_rd = 1'b0;
    chk("result byte", e, res_byte);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    bad_count++;
    give_verdict;
  end
  initial begin
    step(6);
    reset_n_in = 1'b1;
    rchk(FA, 8'h80);
    rchk(PA, 8'h00);
    rchk(DA, 8'h04);
    chk("divider mirror", 5'h04, divm);
    rchk(8'h44, 8'h00);
    u_mfptr_host.wr(DA, 8'hFF);
    rchk(DA, 8'h1F);
    chk("divider mirror", 5'h1F, divm);
    u_mfptr_host.wr(PA, 8'hFF);
    rchk(PA, 8'hC0);
    chk("pin three oe_n", 1'b0, oe_n);
    chk("pin three out", 1'b0, p3_out);
    cfg.pin_three = mfptr_pkg::PIN_IN_HIGH;
    step(2);
    chk("pin three oe_n", 1'b1, oe_n);
    cfg.pin_three = mfptr_pkg::PIN_OUT;
    step(2);
    chk("pin three oe_n", 1'b0, oe_n);
    u_mfptr_host.wr(PA, 8'h00);
    rchk(PA, 8'h00);
    chk("pin three oe_n", 1'b1, oe_n);
    cfg.pin_three = mfptr_pkg::PIN_ALT;
    pulse(5'h10);
    rchk(PA, 8'h80);
    chk("pin three oe_n", 1'b0, oe_n);
    cfg.pin_three = mfptr_pkg::PIN_OUT;
    step(2);
    chk("pin three oe_n", 1'b1, oe_n);
    cfg.pin_three = mfptr_pkg::PIN_ALT;
    u_mfptr_host.wr(PA, 8'h00);
    rchk(PA, 8'h00);
    for (int i = 0; i < 3; i++) begin
      pulse(5'h01 << i);
      u_mfptr_host.wr(FA, 8'hFF);
      rchk(FA, 8'h80 | (8'h01 << i));
      u_mfptr_host.wr(FA, 8'h00);
      rchk(FA, 8'h80);
    end
    pulse(5'h08);
    rchk(FA, 8'h80);
    cb_bits = 8'h10;
    pulse(5'h08);
    rchk(FA, 8'h88);
    cfg = '{mfptr_pkg::PIN_IN_HIGH, mfptr_pkg::PIN_IN_LOW, mfptr_pkg::PIN_IN_HIGH};
    p1 = 1'b1;
    p2 = 1'b0;
    p3 = 1'b1;
    step(2);
    p1 = 1'b0;
    p2 = 1'b1;
    p3 = 1'b0;
    rchk(FA, 8'hF8);
    u_mfptr_host.wr(FA, 8'h00);
    rchk(FA, 8'h80);
    kind = mfptr_pkg::RES_KIND_32;
    val = 32'h1234_5678;
    rbyte(2'h0, 8'h12);
    val = 32'hFFFF_FFFF;
    rbyte(2'h1, 8'h34);
    rbyte(2'h2, 8'h56);
    rbyte(2'h3, 8'h78);
    kind = mfptr_pkg::RES_KIND_24;
    val = 32'h00AB_CDEF;
    rbyte(2'h0, 8'hAB);
    rbyte(2'h1, 8'hCD);
    rbyte(2'h2, 8'hEF);
    rbyte(2'h3, 8'h00);
    kind = mfptr_pkg::RES_KIND_12;
    val = 32'h0000_0ABC;
    rbyte(2'h0, 8'hAB);
    rbyte(2'h1, 8'hC0);
    rbyte(2'h2, 8'h00);
    mode = 8'h03;
    ext = 1'b1;
    u_mfptr_host.wr(DA, 8'h02);
    step(2);
    chk("lsb factor", 26'h271_7530, factor);
    chk("lsb time", 33'h0_138B_A980, ltime);
    mode = 8'h66;
    step(2);
    chk("lsb factor", 26'h271_61A8, factor);
    ext = 1'b0;
    step(2);
    chk("lsb time", 33'h9C5_86A0, ltime);
    ext = 1'b1;
    ticks = 0;
    repeat (16) begin
      tb_in = 1'b1;
      step(1);
      tb_in = 1'b0;
      step(1);
    end
    step(2);
    chk("tick count", 33'h2, ticks);
    give_verdict;
  end
endmodule
`default_nettype wire
